//--- verilog/cic_pkg.sv
// constants shared by the cpu interrupt controller
package cic_pkg;

    // ****************************************************
    // register addresses on the special function bus
    // ****************************************************
    localparam logic [7:0] CIC_ADDR_TIMER_AND_EDGE_IRQ_CONTROL  = 8'h88;
    localparam logic [7:0] CIC_ADDR_IRQ_ENABLE_THIRD  = 8'h9A;
    localparam logic [7:0] CIC_ADDR_IRQ_ENABLE_FIRST  = 8'hA8;
    localparam logic [7:0] CIC_ADDR_IRQ_ENABLE_SECOND  = 8'hB8;
    localparam logic [7:0] CIC_ADDR_IRQ   = 8'hC0;
    localparam logic [7:0] CIC_ADDR_POL   = 8'hC8;

    // ****************************************************
    // reset values
    // ****************************************************
    localparam logic [7:0] CIC_RST_TIMER_AND_EDGE_IRQ_CONTROL   = 8'h00;
    localparam logic [7:0] CIC_RST_IEN    = 8'h00;
    localparam logic [7:0] CIC_RST_IRQ    = 8'h00;
    localparam logic [7:0] CIC_RST_POL    = 8'h00;
    localparam logic [7:0] CIC_RD_UNMAP   = 8'h00;

    // ****************************************************
    // field positions
    // ****************************************************
    localparam int CIC_B_GLOBAL   = 7;
    localparam int CIC_B_SER0_EN  = 4;
    localparam int CIC_B_T1_EN    = 3;
    localparam int CIC_B_X1_EN    = 2;
    localparam int CIC_B_T0_EN    = 1;
    localparam int CIC_B_X0_EN    = 0;
    localparam int CIC_B_LINE_LO  = 1;
    localparam int CIC_B_SER1_EN  = 0;
    localparam int CIC_B_T1_FLAG  = 7;
    localparam int CIC_B_T0_FLAG  = 5;
    localparam int CIC_B_X1_FLAG  = 3;
    localparam int CIC_B_X1_TYPE  = 2;
    localparam int CIC_B_X0_FLAG  = 1;
    localparam int CIC_B_X0_TYPE  = 0;
    localparam int CIC_B_POL3     = 6;
    localparam int CIC_B_POL2     = 5;
    localparam logic [7:0] CIC_POL_MASK  = 8'h60;
    localparam logic [7:0] CIC_LINE_MASK = 8'h3E;

    // ****************************************************
    // sources, levels and timing in machine cycles
    // ****************************************************
    localparam int CIC_N_SLOT      = 10;
    localparam int CIC_N_LVL       = 4;
    localparam int CIC_CALL_CYCLES = 6;
    localparam int CIC_SL_X0 = 0;
    localparam int CIC_SL_T0 = 1;
    localparam int CIC_SL_X1 = 2;
    localparam int CIC_SL_T1 = 3;
    localparam int CIC_SL_SER = 4;
    localparam int CIC_SL_LINE2 = 5;

    typedef enum logic [1:0] {
        CIC_IDLE = 2'b01,
        CIC_CALL = 2'b10
    } cic_state_e;

endpackage : cic_pkg

//--- verilog/cic_core.sv
// cpu interrupt controller: flags, enables, arbitration and forced call
module cic_core
    import cic_pkg::*;
#(
    parameter logic [159:0] VECTORS   = 160'h0048_0043_003B_0033_002B_0023_001B_0013_000B_0003,
    parameter logic [19:0]  SLOT_PRIO = 20'b00_00_01_01_10_10_11_11_11_11
) (
    input  wire logic        clock,
    input  wire logic        sys_rst,
    input  wire logic [7:0]  sfr_addr,
    input  wire logic        sfr_wr,
    input  wire logic        sfr_rd,
    input  wire logic [7:0]  sfr_wdata,
    output logic      [7:0]  sfr_rdata,
    input  wire logic        ext_input_zero,
    input  wire logic        ext_input_one,
    input  wire logic        ext_line_two,
    input  wire logic        ext_line_three,
    input  wire logic [2:0]  periph_line,
    input  wire logic        timer_zero_ovf,
    input  wire logic        timer_one_ovf,
    input  wire logic        serial_zero_req,
    input  wire logic        serial_one_req,
    input  wire logic        instr_boundary,
    input  wire logic        return_from_interrupt,
    output logic             long_subroutine_call,
    output logic      [15:0] call_vector,
    output logic      [3:0]  call_slot,
    output logic             call_busy,
    output logic      [3:0]  service_levels
);

    // ****************************************************
    // storage
    // ****************************************************
    logic [7:0]            timer_and_edge_irq_control_q;
    logic [7:0]            irq_enable_first_q;
    logic [7:0]            irq_enable_second_q;
    logic [7:0]            irq_enable_third_q;
    logic [7:0]            irq_q;
    logic [7:0]            pol_q;
    logic [7:0]            rdata_q;
    logic [4:0]            line_prev_q;
    logic [1:0]            inp_prev_q;
    logic [CIC_N_SLOT-1:0] samp_q;
    logic [CIC_N_LVL-1:0]  svc_q;
    cic_state_e            state_q;
    logic [2:0]            cnt_q;
    logic                  call_q;
    logic [15:0]           vec_q;
    logic [3:0]            slot_q;
    logic [CIC_N_SLOT-1:0] raw_flags;
    logic [CIC_N_SLOT-1:0] armed;
    logic [4:0]            pick;
    logic                  take;
    logic [4:0]            line_edge;
    logic [1:0]            inp_fall;
    logic [CIC_N_SLOT-1:0] ack_clr;

    // ****************************************************
    // helpers
    // ****************************************************
    function automatic logic [1:0] prio_of(input logic [3:0] s);
        prio_of = SLOT_PRIO[2*s +: 2];
    endfunction : prio_of

    // 0 when idle, else level of deepest active service plus one
    function automatic logic [2:0] floor_of(input logic [CIC_N_LVL-1:0] sv);
        floor_of = 3'h0;
        for (int l = 0; l < CIC_N_LVL; l++) begin
            if (sv[l]) begin
                floor_of = 3'(l + 1);
            end
        end
    endfunction : floor_of

    // ****************************************************
    // raw flags, gating and arbitration
    // ****************************************************
    assign raw_flags = {irq_q[5:1],
                        serial_zero_req | serial_one_req,
                        timer_and_edge_irq_control_q[CIC_B_T1_FLAG], timer_and_edge_irq_control_q[CIC_B_X1_FLAG],
                        timer_and_edge_irq_control_q[CIC_B_T0_FLAG], timer_and_edge_irq_control_q[CIC_B_X0_FLAG]};

    // watchdog bits and timer run bits take no part here
    always_comb begin
        armed = {irq_enable_second_q[5:1] & samp_q[9:5],
                 (serial_zero_req & irq_enable_first_q[CIC_B_SER0_EN])
                   | (serial_one_req & irq_enable_third_q[CIC_B_SER1_EN]),
                 samp_q[3] & irq_enable_first_q[CIC_B_T1_EN],
                 samp_q[2] & irq_enable_first_q[CIC_B_X1_EN],
                 samp_q[1] & irq_enable_first_q[CIC_B_T0_EN],
                 samp_q[0] & irq_enable_first_q[CIC_B_X0_EN]};
        armed = armed & {CIC_N_SLOT{samp_q[CIC_SL_SER]}} | armed & ~(CIC_N_SLOT'(1) << CIC_SL_SER);
        if (!irq_enable_first_q[CIC_B_GLOBAL]) begin
            armed = '0;
        end
    end

    // highest priority above the active floor, lowest slot on ties
    always_comb begin
        pick = 5'h00;
        for (int s = CIC_N_SLOT - 1; s >= 0; s--) begin
            if (armed[s] && ({1'b0, prio_of(4'(s))} + 3'h1 > floor_of(svc_q))
                && (!pick[4] || prio_of(4'(s)) >= prio_of(pick[3:0]))) begin
                pick = {1'b1, 4'(s)};
            end
        end
    end

    assign take = (state_q == CIC_IDLE) && instr_boundary && pick[4];

    always_comb begin
        ack_clr = '0;
        if (take) begin
            ack_clr[pick[3:0]] = 1'b1;
        end
    end

    assign line_edge = {periph_line & ~line_prev_q[4:2],
                        (ext_line_three ~^ pol_q[CIC_B_POL3]) & (line_prev_q[1] ^ ext_line_three),
                        (ext_line_two ~^ pol_q[CIC_B_POL2]) & (line_prev_q[0] ^ ext_line_two)};
    assign inp_fall  = inp_prev_q & ~{ext_input_one, ext_input_zero};

    // ****************************************************
    // special function registers
    // ****************************************************
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            irq_enable_first_q <= CIC_RST_IEN;
            irq_enable_second_q <= CIC_RST_IEN;
            irq_enable_third_q <= CIC_RST_IEN;
            pol_q  <= CIC_RST_POL;
        end else if (sfr_wr) begin
            if (sfr_addr == CIC_ADDR_IRQ_ENABLE_FIRST) begin
                irq_enable_first_q <= sfr_wdata;
            end
            if (sfr_addr == CIC_ADDR_IRQ_ENABLE_SECOND) begin
                irq_enable_second_q <= sfr_wdata;
            end
            if (sfr_addr == CIC_ADDR_IRQ_ENABLE_THIRD) begin
                irq_enable_third_q <= sfr_wdata;
            end
            if (sfr_addr == CIC_ADDR_POL) begin
                pol_q <= sfr_wdata & CIC_POL_MASK;
            end
        end
    end

    // hardware set is written last so it wins over a same-cycle clear
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            timer_and_edge_irq_control_q <= CIC_RST_TIMER_AND_EDGE_IRQ_CONTROL;
        end else begin
            if (sfr_wr && sfr_addr == CIC_ADDR_TIMER_AND_EDGE_IRQ_CONTROL) begin
                timer_and_edge_irq_control_q <= sfr_wdata;
            end
            if (ack_clr[CIC_SL_T0]) begin
                timer_and_edge_irq_control_q[CIC_B_T0_FLAG] <= 1'b0;
            end
            if (ack_clr[CIC_SL_T1]) begin
                timer_and_edge_irq_control_q[CIC_B_T1_FLAG] <= 1'b0;
            end
            if (ack_clr[CIC_SL_X0]) begin
                timer_and_edge_irq_control_q[CIC_B_X0_FLAG] <= 1'b0;
            end
            if (ack_clr[CIC_SL_X1]) begin
                timer_and_edge_irq_control_q[CIC_B_X1_FLAG] <= 1'b0;
            end
            if (timer_zero_ovf) begin
                timer_and_edge_irq_control_q[CIC_B_T0_FLAG] <= 1'b1;
            end
            if (timer_one_ovf) begin
                timer_and_edge_irq_control_q[CIC_B_T1_FLAG] <= 1'b1;
            end
            if (timer_and_edge_irq_control_q[CIC_B_X0_TYPE]) begin
                if (inp_fall[0]) begin
                    timer_and_edge_irq_control_q[CIC_B_X0_FLAG] <= 1'b1;
                end
            end else begin
                timer_and_edge_irq_control_q[CIC_B_X0_FLAG] <= ~ext_input_zero;
            end
            if (timer_and_edge_irq_control_q[CIC_B_X1_TYPE]) begin
                if (inp_fall[1]) begin
                    timer_and_edge_irq_control_q[CIC_B_X1_FLAG] <= 1'b1;
                end
            end else begin
                timer_and_edge_irq_control_q[CIC_B_X1_FLAG] <= ~ext_input_one;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            irq_q <= CIC_RST_IRQ;
        end else begin
            irq_q <= (sfr_wr && sfr_addr == CIC_ADDR_IRQ) ? (sfr_wdata & CIC_LINE_MASK)
                     : (irq_q & ~{2'b00, ack_clr[9:5], 1'b0});
            for (int k = 0; k < 5; k++) begin
                if (line_edge[k]) begin
                    irq_q[CIC_B_LINE_LO + k] <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            line_prev_q <= 5'h00;
            inp_prev_q  <= 2'h3;
        end else begin
            line_prev_q <= {periph_line, ext_line_three, ext_line_two};
            inp_prev_q  <= {ext_input_one, ext_input_zero};
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rdata_q <= CIC_RD_UNMAP;
        end else if (sfr_rd) begin
            unique case (sfr_addr)
                CIC_ADDR_TIMER_AND_EDGE_IRQ_CONTROL: rdata_q <= timer_and_edge_irq_control_q;
                CIC_ADDR_IRQ_ENABLE_FIRST: rdata_q <= irq_enable_first_q;
                CIC_ADDR_IRQ_ENABLE_SECOND: rdata_q <= irq_enable_second_q;
                CIC_ADDR_IRQ_ENABLE_THIRD: rdata_q <= irq_enable_third_q;
                CIC_ADDR_IRQ:  rdata_q <= irq_q;
                CIC_ADDR_POL:  rdata_q <= pol_q;
                default:       rdata_q <= CIC_RD_UNMAP;
            endcase
        end
    end

    // ****************************************************
    // sampling, forced call and service levels
    // ****************************************************
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            samp_q <= '0;
        end else begin
            samp_q <= raw_flags;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_q <= CIC_IDLE;
            cnt_q   <= 3'h0;
            call_q  <= 1'b0;
            vec_q   <= 16'h0000;
            slot_q  <= 4'h0;
        end else begin
            call_q <= take;
            unique case (state_q)
                CIC_IDLE: begin
                    if (take) begin
                        state_q <= CIC_CALL;
                        cnt_q   <= 3'(CIC_CALL_CYCLES - 1);
                        vec_q   <= VECTORS[16*pick[3:0] +: 16];
                        slot_q  <= pick[3:0];
                    end
                end
                CIC_CALL: begin
                    if (cnt_q == 3'h0) begin
                        state_q <= CIC_IDLE;
                    end else begin
                        cnt_q <= cnt_q - 3'h1;
                    end
                end
            endcase
        end
    end

    // a return with nothing active is ignored
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            svc_q <= '0;
        end else if (take) begin
            svc_q[prio_of(pick[3:0])] <= 1'b1;
        end else if (return_from_interrupt && floor_of(svc_q) != 3'h0) begin
            svc_q[2'(floor_of(svc_q) - 3'h1)] <= 1'b0;
        end
    end

    assign sfr_rdata            = rdata_q;
    assign long_subroutine_call = call_q;
    assign call_vector          = vec_q;
    assign call_slot            = slot_q;
    assign call_busy            = state_q[1];
    assign service_levels       = svc_q;

    // ****************************************************
    // checks
    // ****************************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    a_global_gate: assert property (long_subroutine_call |-> $past(irq_enable_first_q[CIC_B_GLOBAL]))
        else $error("call taken with global enable low");
    a_call_len: assert property ($rose(call_busy) |-> call_busy [*6] ##1 !call_busy)
        else $error("forced call not six cycles");
    a_call_start: assert property (long_subroutine_call |-> call_busy)
        else $error("call pulse without busy");
    a_vector_match: assert property (long_subroutine_call |-> call_vector == VECTORS[16*call_slot +: 16])
        else $error("vector does not match slot");
    a_preempt_only: assert property (long_subroutine_call |->
        ({1'b0, prio_of(call_slot)} + 3'h1 > floor_of($past(svc_q))))
        else $error("equal or lower priority preempted");
    a_timer_flag: assert property (timer_zero_ovf |=> timer_and_edge_irq_control_q[CIC_B_T0_FLAG])
        else $error("timer zero flag not set");
    a_edge_flag: assert property (timer_and_edge_irq_control_q[CIC_B_X0_TYPE] && inp_fall[0] && !(sfr_wr && sfr_addr == CIC_ADDR_TIMER_AND_EDGE_IRQ_CONTROL)
        |=> timer_and_edge_irq_control_q[CIC_B_X0_FLAG])
        else $error("falling edge missed");
    a_edge_clear: assert property (ack_clr[CIC_SL_X1] && timer_and_edge_irq_control_q[CIC_B_X1_TYPE] && !inp_fall[1]
        && !(sfr_wr && sfr_addr == CIC_ADDR_TIMER_AND_EDGE_IRQ_CONTROL) |=> !timer_and_edge_irq_control_q[CIC_B_X1_FLAG])
        else $error("edge flag not cleared on acknowledge");
    a_return_from_interrupt_level: assert property (return_from_interrupt && !take && svc_q != '0 |=>
        floor_of(svc_q) < floor_of($past(svc_q)))
        else $error("return left level active");
    a_rise_line: assert property (periph_line[0] && !line_prev_q[2] |=> irq_q[3])
        else $error("rising event on line four lost");

    c_call_taken: cover property (long_subroutine_call);
    c_nested: cover property (long_subroutine_call && $past(svc_q) != '0);
    c_return_from_interrupt: cover property (return_from_interrupt && svc_q != '0);

endmodule : cic_core

//--- tb/cic_partner.sv
// partner model: cpu sequencer offering call boundaries and return pulses
module cic_partner (
    input  wire logic clock,
    input  wire logic sys_rst,
    input  wire logic slow,
    input  wire logic ret_go,
    output logic      instr_boundary,
    output logic      return_from_interrupt
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [1:0] div_q;

    // slow mode stands for long instructions: one boundary in four cycles
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            div_q <= 2'h0;
        end else begin
            div_q <= div_q + 2'h1;
        end
    end

    assign instr_boundary = slow ? (div_q == 2'h3) : 1'b1;

    // the return instruction retires one cycle after it is issued
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            return_from_interrupt <= 1'b0;
        end else begin
            return_from_interrupt <= ret_go;
        end
    end
endmodule : cic_partner

//--- tb/test_cpu_interrupt_controller.sv
// self-checking bench for the cpu interrupt controller
module test_cpu_interrupt_controller;
    import cic_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    // vectors are arbitrary, distinct per slot
    localparam logic [159:0] VECS = 160'hA009_A008_A007_A006_A005_A004_A003_A002_A001_A000;
    typedef struct {logic [3:0] slot; bit timed; time t;} cic_note_s;

    logic        clock, sys_rst, sfr_wr, sfr_rd, slow, ret_go;
    logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata;
    logic        ext_input_zero, ext_input_one, ext_line_two, ext_line_three;
    logic [2:0]  periph_line;
    logic        timer_zero_ovf, timer_one_ovf, serial_zero_req, serial_one_req;
    logic        instr_boundary, return_from_interrupt, long_subroutine_call, call_busy;
    logic [15:0] call_vector;
    logic [3:0]  call_slot, service_levels;
    logic [7:0]  exp_rd[$];
    cic_note_s   exp_call[$];
    cic_note_s   note;
    logic        rd_taken;
    int          miscompares, n_tests, n_calls, busy_n, i, seed;
    time         last_t;
    logic [31:0] r;

    cic_core #(.VECTORS(VECS)) u_cic_core (
        .clock(clock), .sys_rst(sys_rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
        .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .ext_input_zero(ext_input_zero),
        .ext_input_one(ext_input_one), .ext_line_two(ext_line_two), .ext_line_three(ext_line_three),
        .periph_line(periph_line), .timer_zero_ovf(timer_zero_ovf), .timer_one_ovf(timer_one_ovf),
        .serial_zero_req(serial_zero_req), .serial_one_req(serial_one_req),
        .instr_boundary(instr_boundary), .return_from_interrupt(return_from_interrupt),
        .long_subroutine_call(long_subroutine_call), .call_vector(call_vector), .call_slot(call_slot),
        .call_busy(call_busy), .service_levels(service_levels));

    cic_partner u_cic_partner (
        .clock(clock), .sys_rst(sys_rst), .slow(slow), .ret_go(ret_go),
        .instr_boundary(instr_boundary), .return_from_interrupt(return_from_interrupt));

    // ****************************************************
    // compare and report
    // ****************************************************
    task automatic chk_reg(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            $display("mismatch %s expected %h seen %h", nm, e, g);
            miscompares++;
        end
    endtask : chk_reg

    task automatic chk_val(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            $display("mismatch %s expected %h seen %h", nm, e, g);
            miscompares++;
        end
    endtask : chk_val

    task automatic wrap_up();
        if (miscompares == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : wrap_up

    // ****************************************************
    // drivers
    // ****************************************************
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask : cyc

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        sfr_addr  <= a;
        sfr_wdata <= d;
        sfr_wr    <= 1'b1;
        @(posedge clock);
        sfr_wr    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_rd.push_back(e);
        @(posedge clock);
        sfr_addr <= a;
        sfr_rd   <= 1'b1;
        @(posedge clock);
        sfr_rd   <= 1'b0;
    endtask : rd

    // one-cycle event on a source, numbered by slot
    task automatic evt(input int k);
        @(posedge clock);
        last_t = $time;
        case (k)
            0: ext_input_zero <= 1'b0;
            1: timer_zero_ovf <= 1'b1;
            2: ext_input_one <= 1'b0;
            3: timer_one_ovf <= 1'b1;
            5: ext_line_two <= 1'b1;
            6: ext_line_three <= 1'b1;
            default: periph_line[k-7] <= 1'b1;
        endcase
        @(posedge clock);
        ext_input_zero <= 1'b1;
        ext_input_one  <= 1'b1;
        timer_zero_ovf <= 1'b0;
        timer_one_ovf  <= 1'b0;
        ext_line_two   <= 1'b0;
        ext_line_three <= 1'b0;
        periph_line    <= 3'h0;
    endtask : evt

    task automatic expect_call(input logic [3:0] s, input bit timed);
        exp_call.push_back('{s, timed, last_t});
    endtask : expect_call

    // bounded wait: call count reached and forced call finished
    task automatic wait_calls(input int target);
        int k;
        for (k = 0; k < 200 && !(n_calls >= target && call_busy === 1'b0); k++) @(posedge clock);
        if (k == 200) begin
            $display("mismatch call_count expected %0d seen %0d", target, n_calls);
            miscompares++;
            wrap_up();
        end
    endtask : wait_calls

    task automatic ret();
        @(posedge clock);
        ret_go <= 1'b1;
        @(posedge clock);
        ret_go <= 1'b0;
        cyc(2);
    endtask : ret

    // ****************************************************
    // monitor: results taken against the oldest note
    // ****************************************************
    always @(posedge clock) rd_taken <= sfr_rd;

    always @(negedge clock) begin
        if (rd_taken === 1'b1) begin
            if (exp_rd.size() == 0) begin
                $display("mismatch read_data expected none seen %h", sfr_rdata);
                miscompares++;
            end else begin
                chk_reg("read_data", exp_rd.pop_front(), sfr_rdata);
            end
        end
        if (long_subroutine_call === 1'b1) begin
            n_calls++;
            if (exp_call.size() == 0) begin
                $display("mismatch call_slot expected none seen %h", call_slot);
                miscompares++;
            end else begin
                note = exp_call.pop_front();
                chk_val("call_slot", 16'(note.slot), 16'(call_slot));
                chk_val("call_vector", VECS[note.slot*16 +: 16], call_vector);
                if (note.timed) chk_val("call_latency", 16'd3, 16'(($time - note.t) / 100));
            end
        end
        if (call_busy === 1'b1) begin
            busy_n++;
        end else if (busy_n != 0) begin
            chk_val("call_busy_len", 16'(CIC_CALL_CYCLES), 16'(busy_n));
            busy_n = 0;
        end
    end

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    // hang guard
    initial begin
        repeat (20000) @(posedge clock);
        $display("mismatch run_length expected finish seen hang");
        miscompares++;
        wrap_up();
    end

    initial begin
        {sys_rst, sfr_wr, sfr_rd, slow, ret_go} = 5'b10000;
        {sfr_addr, sfr_wdata, periph_line} = 19'h0;
        {ext_input_zero, ext_input_one, ext_line_two, ext_line_three} = 4'b1100;
        {timer_zero_ovf, timer_one_ovf, serial_zero_req, serial_one_req} = 4'h0;
        {miscompares, n_tests, n_calls, busy_n, seed} = {32'd0, 32'd0, 32'd0, 32'd0, 32'd86};
        last_t = 0;
        cyc(4);
        sys_rst <= 1'b0;
        // reset values of all six mapped registers
        rd(CIC_ADDR_TIMER_AND_EDGE_IRQ_CONTROL, 8'h00);
        rd(CIC_ADDR_IRQ_ENABLE_FIRST, 8'h00);
        rd(CIC_ADDR_IRQ_ENABLE_SECOND, 8'h00);
        rd(CIC_ADDR_IRQ_ENABLE_THIRD, 8'h00);
        rd(CIC_ADDR_IRQ, 8'h00);
        rd(CIC_ADDR_POL, 8'h00);
        // level mode: flag follows the low pin
        ext_input_one <= 1'b0;
        cyc(2);
        rd(CIC_ADDR_TIMER_AND_EDGE_IRQ_CONTROL, 8'h08);
        ext_input_one <= 1'b1;
        cyc(2);
        // enables with global bit clear, watchdog bits set
        wr(CIC_ADDR_IRQ_ENABLE_SECOND, 8'h7E);
        wr(CIC_ADDR_IRQ_ENABLE_THIRD, 8'h01);
        wr(CIC_ADDR_IRQ_ENABLE_FIRST, 8'h5F);
        rd(CIC_ADDR_IRQ_ENABLE_SECOND, 8'h7E);
        rd(CIC_ADDR_IRQ_ENABLE_THIRD, 8'h01);
        rd(CIC_ADDR_IRQ_ENABLE_FIRST, 8'h5F);
        wr(8'h90, 8'hFF);
        rd(8'h90, CIC_RD_UNMAP);
        for (i = 0; i < 4; i++) begin
            r = $random(seed);
            wr(CIC_ADDR_POL, r[7:0]);
            rd(CIC_ADDR_POL, r[7:0] & CIC_POL_MASK);
        end
        wr(CIC_ADDR_POL, 8'h40);
        wr(CIC_ADDR_TIMER_AND_EDGE_IRQ_CONTROL, 8'h05);
        // flags set while globally disabled; no call may follow
        evt(0);
        evt(1);
        evt(2);
        evt(3);
        evt(5);
        evt(6);
        evt(7);
        cyc(3);
        rd(CIC_ADDR_TIMER_AND_EDGE_IRQ_CONTROL, 8'hAF);
        rd(CIC_ADDR_IRQ, 8'h0E);
        // global on: pending sources drain in priority then slot order
        expect_call(4'd0, 1'b0);
        expect_call(4'd1, 1'b0);
        expect_call(4'd2, 1'b0);
        expect_call(4'd3, 1'b0);
        expect_call(4'd5, 1'b0);
        expect_call(4'd6, 1'b0);
        expect_call(4'd7, 1'b0);
        wr(CIC_ADDR_IRQ_ENABLE_FIRST, 8'hDF);
        for (i = 1; i <= 7; i++) begin
            wait_calls(i);
            ret();
        end
        rd(CIC_ADDR_TIMER_AND_EDGE_IRQ_CONTROL, 8'h05);
        rd(CIC_ADDR_IRQ, 8'h00);
        chk_val("service_levels", 16'h0, 16'(service_levels));
        // preemption by a strictly higher level only
        evt(7);
        expect_call(4'd7, 1'b0);
        wait_calls(8);
        evt(1);
        expect_call(4'd1, 1'b1);
        wait_calls(9);
        chk_val("service_levels", 16'hA, 16'(service_levels));
        evt(5);
        cyc(8);
        expect_call(4'd5, 1'b0);
        ret();
        wait_calls(10);
        chk_val("service_levels", 16'h6, 16'(service_levels));
        ret();
        ret();
        chk_val("service_levels", 16'h0, 16'(service_levels));
        // serial pair on one slot, each behind its own enable; slow boundaries
        wr(CIC_ADDR_IRQ_ENABLE_FIRST, 8'hCF);
        serial_zero_req <= 1'b1;
        cyc(10);
        serial_zero_req <= 1'b0;
        slow <= 1'b1;
        serial_one_req <= 1'b1;
        expect_call(4'd4, 1'b0);
        wait_calls(11);
        serial_one_req <= 1'b0;
        ret();
        slow <= 1'b0;
        // reset in mid-run
        sys_rst <= 1'b1;
        cyc(2);
        sys_rst <= 1'b0;
        rd(CIC_ADDR_IRQ_ENABLE_FIRST, 8'h00);
        rd(CIC_ADDR_POL, 8'h00);
        cyc(5);
        if (exp_call.size() != 0 || exp_rd.size() != 0) begin
            $display("mismatch queue_left expected 0 seen %0d", exp_call.size() + exp_rd.size());
            miscompares++;
        end
        wrap_up();
    end
endmodule : test_cpu_interrupt_controller
